/* File: rtl/pixel_shifter.sv */
// Reconfigurable 16-bit pixel shifter feeding the palette
module pixel_shifter
	import video_fetch_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_pixel_depth_select,
	input wire logic i_load,
	input wire logic i_hold,
	input wire logic [WORD_W-1:0] i_word,
	output logic [PIX_W-1:0] o_pixel
);
	logic [WORD_W-1:0] sh_r;
	logic [WORD_W-1:0] load_word;
	logic [WORD_W-1:0] shift_nxt;
	logic [WORD_W-1:0] plane_word;

	// Mixed endian: low byte MSB leaves first, then the high byte
	assign load_word = {i_word[7:0], i_word[15:8]};

	// Colour mode routes bit b of each nibble into chain b, so the four
	// chain heads together form one whole pixel, leftmost nibble first
	always_comb begin
		plane_word = '0;
		for (int b = 0; b < 4; b++) begin
			for (int k = 0; k < 4; k++) begin
				plane_word[b*4+k] = load_word[k*4+b];
			end
		end
	end

	// Same flops, routing picks one 16-bit chain or four 4-bit chains
	always_comb begin
		shift_nxt = {sh_r[14:0], 1'b0};
		if (i_pixel_depth_select) begin
			for (int c = 0; c < 4; c++) begin
				shift_nxt[c*4 +: 4] = {sh_r[c*4 +: 3], 1'b0};
			end
		end
	end

	// Shift chains; colour mode holds on odd dots for double-wide pixels
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sh_r <= '0;
		end else if (i_load) begin
			sh_r <= i_pixel_depth_select ? plane_word : load_word;
		end else if (!(i_pixel_depth_select && i_hold)) begin
			sh_r <= shift_nxt;
		end
	end

	// One 4-bit pixel per clock in mono mode, one per two clocks in colour mode
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_pixel <= '0;
		end else if (i_pixel_depth_select) begin
			o_pixel <= {sh_r[15], sh_r[11], sh_r[7], sh_r[3]};
		end else begin
			o_pixel <= sh_r[15] ? MONO_INDEX_SET : MONO_INDEX_CLEAR;
		end
	end
endmodule

/* File: rtl/video_fetch_and_palette.sv */
// Video address generation, shifter control and palette with border/black
// Overview of operation
// - The shifter flops form one 16-bit chain in 1-bit mode or four 4-bit chains in 4-bit mode.
// - Fetches are whole 16-bit words so the address has no bit 0.
// - In 1-bit mode the address is line count 8..0 then dot count 8..4.
// - In 4-bit mode the address is line count 8..1 then dot count 8..3, repeating lines.
// - Vertical data-valid drops at line 400 so no address exceeds 0x31FF.
// - Address bits 15 and 16 are always zero.
// - The shifter gives one 4-bit pixel per clock in 1-bit mode and one per two clocks in 4-bit mode.
// - The palette is a dual-port RAM mapping 4-bit pixels to 12-bit RGB.
// - In the border the palette is read at the border entry instead.
// - During retrace the colour output is black.
// - Data-valid is delayed one clock for the border select and blanking two clocks for the black output.
// - Mono pixels pick entry 0 or 15; colour nibbles pick any of 16.
// - The border entry is the low four bits of the border colour write.
// - Palette write stages red/green, then commits blue with index in high nibble.
// - The shifter reloads every 16 or 8 clocks under data-valid, never otherwise.
module video_fetch_and_palette
	import video_fetch_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire beam_t i_beam,
	input wire logic i_pixel_depth_select,
	input wire logic [WORD_W-1:0] i_mem_data,
	input wire logic i_border_we,
	input wire logic [7:0] i_border_data,
	input wire logic i_palette_red_green_stage,
	input wire logic i_palette_blue_commit,
	input wire logic [7:0] i_wr_data,
	output logic [ADDR_W:0] o_video_word_address,
	output logic o_fetch,
	output rgb_t o_rgb
);
	logic [3:0] dot_phase;
	logic [3:0] fetch_last;
	logic vert_valid;
	logic fetch_now;
	logic load_r;
	logic [PIX_W-1:0] pixel;
	logic [PIX_W-1:0] border_index_r;
	logic [7:0] rg_stage_r;
	logic [COLOR_W-1:0] palette_r [PAL_DEPTH];
	logic [PIX_W-1:0] read_index;
	logic [COLOR_W-1:0] pal_out_r;
	logic [DELAY_STAGES-1:0] valid_dly_r;
	logic [DELAY_STAGES-1:0] blank_dly_r;
	logic border_sel;

	// Fetch phase comes from the dot counter, no private counter to drift
	assign dot_phase = i_beam.horizontal_dot_count[3:0];
	assign fetch_last = i_pixel_depth_select ? COLOR_FETCH_LAST
		: MONO_FETCH_LAST;

	// Gate on line count too, guarding against a late valid flag
	assign vert_valid = i_beam.vertical_line_count < VERT_ACTIVE_LINES;

	// Fetch one word ahead so it lands at the start of the next group
	assign fetch_now = i_beam.active_video_flag && vert_valid
		&& ((dot_phase & fetch_last) == fetch_last);
	assign o_fetch = fetch_now;

	// Word address from counters; bit 0 absent, top bits tied low
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_video_word_address <= '0;
		end else if (fetch_now) begin
			// Bit 0 here is byte address bit 1, so 14 and 15 carry the two
			// always-zero video lines and 16 is spare
			o_video_word_address[16:14] <= 3'h0;
			if (i_pixel_depth_select) begin
				o_video_word_address[13:0] <= {
					i_beam.vertical_line_count[8:1],
					i_beam.horizontal_dot_count[8:3]
						+ 6'h01};
			end else begin
				o_video_word_address[13:0] <= {
					i_beam.vertical_line_count[8:0],
					i_beam.horizontal_dot_count[8:4]
						+ 5'h01};
			end
		end
	end

	// Data is returned the clock after the fetch, as the new address is presented
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			load_r <= 1'b0;
		end else begin
			load_r <= fetch_now;
		end
	end

	pixel_shifter u_shifter (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_pixel_depth_select(i_pixel_depth_select),
		.i_load(load_r),
		.i_hold(dot_phase[0]),
		.i_word(i_mem_data),
		.o_pixel(pixel)
	);

	// Border colour register, write only; only the low nibble is kept
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			border_index_r <= BORDER_RESET;
		end else if (i_border_we) begin
			border_index_r <= i_border_data[3:0];
		end
	end

	// Red/green staging; software must write it before the commit
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rg_stage_r <= RG_RESET;
		end else if (i_palette_red_green_stage) begin
			rg_stage_r <= i_wr_data;
		end
	end

	// Palette write port, one entry per generate slot
	for (genvar e = 0; e < PAL_DEPTH; e++) begin : g_pal
		always_ff @(posedge i_clk or negedge i_rst_n) begin
			if (!i_rst_n) begin
				palette_r[e] <= PAL_RESET;
			end else if (i_palette_blue_commit
				&& i_wr_data[7:4] == PIX_W'(e)) begin
				palette_r[e] <= {rg_stage_r, i_wr_data[3:0]};
			end
		end
	end

	// Flags delayed to match shifter and palette read stages
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			valid_dly_r <= '0;
			blank_dly_r <= '0;
		end else begin
			valid_dly_r <= {valid_dly_r[0],
				i_beam.active_video_flag && vert_valid};
			blank_dly_r <= {blank_dly_r[0], i_beam.retrace_blank};
		end
	end

	// Border when neither active nor retrace at the pixel's own time
	assign border_sel = !valid_dly_r[0] && !blank_dly_r[0];
	assign read_index = border_sel ? border_index_r : pixel;

	// Palette read port, registered like a block RAM
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pal_out_r <= BLACK;
		end else begin
			pal_out_r <= palette_r[read_index];
		end
	end

	// Black in retrace; monitors misbehave if driven then
	always_comb begin
		o_rgb = pal_out_r;
		if (blank_dly_r[1]) begin
			o_rgb = BLACK;
		end
	end
endmodule

/* File: rtl/video_fetch_pkg.sv */
// Constants and carrier types for the video fetch and palette back end
package video_fetch_pkg;
	localparam int COUNT_W = 10;
	localparam int ADDR_W = 16;
	localparam int WORD_W = 16;
	localparam int PIX_W = 4;
	localparam int COLOR_W = 12;
	localparam int PAL_DEPTH = 16;
	localparam logic [COUNT_W-1:0] VERT_ACTIVE_LINES = 10'h190;
	localparam logic [3:0] MONO_FETCH_LAST = 4'hF;
	localparam logic [3:0] COLOR_FETCH_LAST = 4'h7;
	localparam logic [PIX_W-1:0] MONO_INDEX_CLEAR = 4'h0;
	localparam logic [PIX_W-1:0] MONO_INDEX_SET = 4'hF;
	localparam int DELAY_STAGES = 2;
	localparam logic [COLOR_W-1:0] BLACK = 12'h000;
	localparam logic [COLOR_W-1:0] PAL_RESET = 12'h000;
	localparam logic [3:0] BORDER_RESET = 4'h0;
	localparam logic [7:0] RG_RESET = 8'h00;

	// Beam position and timing flags from the counters
	typedef struct packed {
		logic [COUNT_W-1:0] horizontal_dot_count;
		logic [COUNT_W-1:0] vertical_line_count;
		logic active_video_flag;
		logic retrace_blank;
	} beam_t;

	// Colour output to the DACs
	typedef struct packed {
		logic [3:0] red;
		logic [3:0] green;
		logic [3:0] blue;
	} rgb_t;
endpackage

/* File: verif/tb_video_fetch_and_palette.sv */
// Self-checking bench for the video fetch and palette back end
module tb_video_fetch_and_palette;
	import video_fetch_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic i_clk, i_rst_n, mode, bwe, stg, cmt, fetch;
	beam_t beam;
	logic [15:0] mdat, fill;
	logic [7:0] bdat, wdat;
	logic [16:0] addr;
	rgb_t rgb;
	int num_errors, n_compared, nf;
	video_fetch_and_palette u_dut (.i_clk(i_clk), .i_rst_n(i_rst_n),
		.i_beam(beam), .i_pixel_depth_select(mode), .i_mem_data(mdat),
		.i_border_we(bwe), .i_border_data(bdat),
		.i_palette_red_green_stage(stg), .i_palette_blue_commit(cmt),
		.i_wr_data(wdat), .o_video_word_address(addr), .o_fetch(fetch),
		.o_rgb(rgb));
	video_mem_model u_mem (.i_clk(i_clk), .i_fetch(fetch), .i_word(fill),
		.o_data(mdat));
	// Free-running system clock
	initial begin
		i_clk = 1'b0;
		forever #25 i_clk = ~i_clk;
	end
	// Distinct colour per entry so a wrong index shows
	function automatic logic [11:0] col(input logic [3:0] i);
		return {i, ~i, i ^ 4'h6};
	endfunction
	task automatic chk(input logic [16:0] seen, exp);
		n_compared++;
		if (seen !== exp)
			$display("Error at %0t: saw %h want %h", $time, seen, exp);
		if (seen !== exp)
			num_errors++;
	endtask
	// Two-step entry write: red/green staged first
	task automatic pal(input logic [3:0] i);
		@(negedge i_clk);
		stg = 1'b1;
		wdat = 8'(col(i) >> 4);
		@(negedge i_clk);
		stg = 1'b0;
		cmt = 1'b1;
		wdat = {i, 4'(col(i))};
		@(negedge i_clk);
		cmt = 1'b0;
	endtask
	// One line of 64 dots; fetches counted, colour checked after
	task automatic scen(input logic m, v, b, input logic [15:0] w,
		input logic [9:0] ln, input int nexp, input logic [11:0] cexp);
		mode = m;
		fill = w;
		nf = 0;
		for (int d = 0; d < 64; d++) begin
			@(negedge i_clk);
			beam = {10'(d), ln, v, b};
			@(posedge i_clk);
			nf += fetch;
		end
		@(negedge i_clk);
		chk(17'(nf), 17'(nexp));
		chk(17'(rgb), 17'(cexp));
		$display("Test done: line %0d mode %0d", ln, m);
	endtask
	task automatic wrap_up;
		$display("Compared %0d, mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial begin
		{i_rst_n, mode, bwe, stg, cmt} = 5'h00;
		beam = '0;
		{fill, bdat, wdat} = 32'h0;
		num_errors = 0;
		n_compared = 0;
		repeat (6) @(negedge i_clk);
		chk(addr, 17'h00000);
		i_rst_n = 1'b1;
		pal(4'h0);
		pal(4'h5);
		pal(4'hF);
		pal(4'h9);
		bwe = 1'b1;
		bdat = 8'hF9;
		@(negedge i_clk);
		bwe = 1'b0;
		scen(0, 0, 0, 16'h0000, 10'h1C2, 0, col(9));
		scen(0, 0, 1, 16'hFFFF, 10'h1C2, 0, BLACK);
		scen(0, 1, 0, 16'hFFFF, 10'h18F, 4, col(15));
		chk(addr, {3'h0, 9'h18F, 5'h04});
		scen(0, 1, 0, 16'h0000, 10'h18F, 4, col(0));
		scen(1, 1, 0, 16'h5555, 10'h18E, 8, col(5));
		chk(addr, {3'h0, 8'hC7, 6'h08});
		scen(1, 1, 0, 16'h5555, 10'h18F, 8, col(5));
		chk(addr, {3'h0, 8'hC7, 6'h08});
		scen(1, 1, 1, 16'h5555, 10'h190, 0, BLACK);
		wrap_up();
	end
endmodule

/* File: verif/video_fetch_monitor.sv */
// Checker for address, fetch gating and colour forcing
module video_fetch_monitor
	import video_fetch_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire beam_t i_beam,
	input wire logic i_pixel_depth_select,
	input wire logic [ADDR_W:0] o_video_word_address,
	input wire logic o_fetch,
	input wire rgb_t o_rgb
);
	default clocking @(posedge i_clk);
	endclocking
	default disable iff (!i_rst_n);
	// Beam fields and the address each mode should register
	wire [9:0] ln = i_beam.vertical_line_count;
	wire [9:0] dt = i_beam.horizontal_dot_count;
	wire ok = i_beam.active_video_flag && ln < VERT_ACTIVE_LINES;
	wire [13:0] a0 = {ln[8:0], 5'(dt[8:4] + 5'h01)};
	wire [13:0] a1 = {ln[8:1], 6'(dt[8:3] + 6'h01)};
	sequence s_f0;
		o_fetch && !i_pixel_depth_select;
	endsequence
	sequence s_f1;
		o_fetch && i_pixel_depth_select;
	endsequence
	sequence s_blank;
		i_beam.retrace_blank ##2 1'b1;
	endsequence
	property p_m0;
		s_f0 |=> o_video_word_address == {3'h0, $past(a0)};
	endproperty
	a_m0: assert property (p_m0) else $error("mono address wrong");
	property p_m1;
		s_f1 |=> o_video_word_address == {3'h0, $past(a1)};
	endproperty
	a_m1: assert property (p_m1) else $error("colour address wrong");
	property p_hi;
		o_video_word_address[16:14] == 3'h0;
	endproperty
	a_hi: assert property (p_hi) else $error("upper address set");
	property p_lim;
		o_video_word_address <= 17'h031FF;
	endproperty
	a_lim: assert property (p_lim) else $error("address over top");
	property p_nof;
		!ok |-> !o_fetch;
	endproperty
	a_nof: assert property (p_nof) else $error("fetch outside");
	property p_f0;
		ok && !i_pixel_depth_select |-> o_fetch == (dt[3:0] == 4'hF);
	endproperty
	a_f0: assert property (p_f0) else $error("mono fetch rate");
	property p_f1;
		ok && i_pixel_depth_select |-> o_fetch == (dt[2:0] == 3'h7);
	endproperty
	a_f1: assert property (p_f1) else $error("colour fetch rate");
	property p_hold;
		!o_fetch |=> $stable(o_video_word_address);
	endproperty
	a_hold: assert property (p_hold) else $error("address moved");
	property p_blk;
		s_blank |-> o_rgb == BLACK;
	endproperty
	a_blk: assert property (p_blk) else $error("retrace not black");
endmodule
bind video_fetch_and_palette video_fetch_monitor u_mon (.i_clk(i_clk),
	.i_rst_n(i_rst_n), .i_beam(i_beam),
	.i_pixel_depth_select(i_pixel_depth_select),
	.o_video_word_address(o_video_word_address), .o_fetch(o_fetch),
	.o_rgb(o_rgb));

/* File: verif/video_mem_model.sv */
// Video memory stand-in answering each fetch one cycle later
module video_mem_model (
	input wire logic i_clk,
	input wire logic i_fetch,
	input wire logic [15:0] i_word,
	output logic [15:0] o_data
);
	timeunit 1ns;
	timeprecision 1ns;
	logic fetch_d_r;
	// Outside the answer cycle the bus shows the inverse, never a held value
	always_ff @(posedge i_clk)
		fetch_d_r <= i_fetch;
	assign o_data = fetch_d_r ? i_word : ~i_word;
endmodule
